// File: break_d_match.sv
// Channel D address mask and data compare logic with its register port.
// Assumes bus cycle inputs share mclk_in; manual reset comes from a pin.
//
// Operation
// R1 - Address mask bit one drops that bit.
// R2 - Address mask halves follow the bus selection.
// R3 - Internal bus: high register is bits 31-16.
// R4 - X bus vs high, Y bus vs low.
// R5 - Compare and mask are 16-bit read/write halves.
// R6 - Each mask bit governs same compare bit.
// R7 - Active data mask half follows bus selection.
// R8 - Power-on reset clears mask halves.
// R9 - Enable zero internal bus, one X/Y.
// R10 - Select zero X, one Y, when enabled.
// R11 - Data mask bit one drops that bit.
// R12 - Data match only on qualifying cycle.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module break_d_match (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        manual_reset_n_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        cyc_valid_in,
  input  wire logic [31:0] cyc_addr_in,
  input  wire logic [31:0] cyc_data_in,
  input  wire logic        x_valid_in,
  input  wire logic [15:0] x_addr_in,
  input  wire logic [15:0] x_data_lines_in,
  input  wire logic        y_valid_in,
  input  wire logic [15:0] y_addr_in,
  input  wire logic [15:0] y_data_lines_in,
  output logic             addr_match_out,
  output logic             data_match_out,
  output logic             irq_out
);

  logic [15:0] addr_cmp_high;
  logic [15:0] addr_cmp_low;
  logic [15:0] addr_mask_high;
  logic [15:0] addr_mask_low;
  logic [15:0] data_cmp_high;
  logic [15:0] data_cmp_low;
  logic [15:0] data_mask_high;
  logic [15:0] data_mask_low;
  logic        xy_bus_enable;
  logic        xy_lane_select;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        mrst_meta;
  logic        mrst_sync;
  logic        first_cycle;

  // Places the selected lane in its half of a 32-bit word.
  function automatic logic [31:0] lane_value(
    input logic [31:0] wide,
    input logic [15:0] x_half,
    input logic [15:0] y_half,
    input logic        enable,
    input logic        select
  );
    if (!enable) begin
      return wide;
    end else if (!select) begin
      return {x_half, break_d_pkg::HALF_ZERO};
    end else begin
      return {break_d_pkg::HALF_ZERO, y_half};
    end
  endfunction

  // Forces the unused half of a mask to all ones.
  function automatic logic [31:0] lane_mask(
    input logic [31:0] mask,
    input logic        enable,
    input logic        select
  );
    if (!enable) begin
      return mask;
    end else if (!select) begin
      return {mask[31:16], break_d_pkg::HALF_ONES};
    end else begin
      return {break_d_pkg::HALF_ONES, mask[15:0]};
    end
  endfunction

  wire logic        wr_addr_high  = reg_wr_in && reg_addr_in == break_d_pkg::OFF_ADDR_HIGH;
  wire logic        wr_addr_low   = reg_wr_in && reg_addr_in == break_d_pkg::OFF_ADDR_LOW;
  wire logic        wr_amask_high = reg_wr_in && reg_addr_in == break_d_pkg::OFF_AMASK_HIGH;
  wire logic        wr_amask_low  = reg_wr_in && reg_addr_in == break_d_pkg::OFF_AMASK_LOW;
  wire logic        wr_data_high  = reg_wr_in && reg_addr_in == break_d_pkg::OFF_DATA_HIGH;
  wire logic        wr_data_low   = reg_wr_in && reg_addr_in == break_d_pkg::OFF_DATA_LOW;
  wire logic        wr_dmask_high = reg_wr_in && reg_addr_in == break_d_pkg::OFF_DMASK_HIGH;
  wire logic        wr_dmask_low  = reg_wr_in && reg_addr_in == break_d_pkg::OFF_DMASK_LOW;
  wire logic        wr_bus_ctrl   = reg_wr_in && reg_addr_in == break_d_pkg::OFF_BUS_CTRL;
  wire logic        wr_irq_status = reg_wr_in && reg_addr_in == break_d_pkg::OFF_IRQ_STATUS;
  wire logic        wr_irq_mask   = reg_wr_in && reg_addr_in == break_d_pkg::OFF_IRQ_MASK;
  wire logic        manual_reset  = mrst_sync;

  // Bus selection: internal bus, X lane or Y lane.
  wire logic        qualifying = xy_bus_enable ? (xy_lane_select ? y_valid_in : x_valid_in)
                                               : cyc_valid_in; // R9 R10 R12
  wire logic [31:0] addr_value = lane_value(cyc_addr_in, x_addr_in, y_addr_in,
                                            xy_bus_enable, xy_lane_select); // R2 R9 R10
  wire logic [31:0] data_value = lane_value(cyc_data_in, x_data_lines_in, y_data_lines_in,
                                            xy_bus_enable, xy_lane_select); // R3 R4
  wire logic [31:0] addr_cmp   = {addr_cmp_high, addr_cmp_low};
  wire logic [31:0] data_cmp   = {data_cmp_high, data_cmp_low}; // R3
  // X/Y accesses are word wide, so address bit 0 of the lane never counts.
  wire logic [31:0] xy_word    = !xy_bus_enable ? 32'h0000_0000 :
                                 xy_lane_select ? {break_d_pkg::HALF_ZERO, break_d_pkg::WORD_BIT0}
                                                : {break_d_pkg::WORD_BIT0, break_d_pkg::HALF_ZERO};
  wire logic [31:0] addr_mask  = lane_mask({addr_mask_high, addr_mask_low},
                                           xy_bus_enable, xy_lane_select) | xy_word; // R1 R2
  wire logic [31:0] data_mask  = lane_mask({data_mask_high, data_mask_low},
                                           xy_bus_enable, xy_lane_select); // R6 R7 R11
  wire logic        addr_hit;
  wire logic        data_hit;
  wire logic [1:0]  events     = {data_match_out, addr_match_out};
  wire logic [15:0] ctrl_view  = {6'h00, xy_bus_enable, xy_lane_select, 8'h00};
  wire logic [15:0] state_view = {12'h000, xy_lane_select, xy_bus_enable,
                                  data_match_out, addr_match_out};
  logic      [15:0] read_mux;

  masked_compare #(.WIDTH(break_d_pkg::BUS_W)) addr_compare (
    .value_in   (addr_value),
    .compare_in (addr_cmp),
    .mask_in    (addr_mask),
    .hit_out    (addr_hit)
  );

  masked_compare #(.WIDTH(break_d_pkg::BUS_W)) data_compare (
    .value_in   (data_value),
    .compare_in (data_cmp),
    .mask_in    (data_mask),
    .hit_out    (data_hit)
  );

  always_comb begin
    case (reg_addr_in)
      break_d_pkg::OFF_ADDR_HIGH:   read_mux = addr_cmp_high;
      break_d_pkg::OFF_ADDR_LOW:    read_mux = addr_cmp_low;
      break_d_pkg::OFF_AMASK_HIGH:  read_mux = addr_mask_high;
      break_d_pkg::OFF_AMASK_LOW:   read_mux = addr_mask_low;
      break_d_pkg::OFF_DATA_HIGH:   read_mux = data_cmp_high; // R5
      break_d_pkg::OFF_DATA_LOW:    read_mux = data_cmp_low; // R5
      break_d_pkg::OFF_DMASK_HIGH:  read_mux = data_mask_high; // R5
      break_d_pkg::OFF_DMASK_LOW:   read_mux = data_mask_low; // R5
      break_d_pkg::OFF_BUS_CTRL:    read_mux = ctrl_view;
      break_d_pkg::OFF_IRQ_STATUS:  read_mux = {14'h0000, irq_status};
      break_d_pkg::OFF_IRQ_MASK:    read_mux = {14'h0000, irq_mask};
      break_d_pkg::OFF_MATCH_STATE: read_mux = state_view;
      default:                      read_mux = break_d_pkg::HALF_ZERO;
    endcase
  end

  // Manual reset pin is synchronised before use.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mrst_meta <= 1'b0;
      mrst_sync <= 1'b0;
    end else begin
      mrst_meta <= !manual_reset_n_in;
      mrst_sync <= mrst_meta;
    end
  end

  // Compare and mask halves clear only on power-on reset.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_cmp_high  <= break_d_pkg::RESET_HALF;
      addr_cmp_low   <= break_d_pkg::RESET_HALF;
      addr_mask_high <= break_d_pkg::RESET_HALF;
      addr_mask_low  <= break_d_pkg::RESET_HALF;
      data_cmp_high  <= break_d_pkg::RESET_HALF;
      data_cmp_low   <= break_d_pkg::RESET_HALF;
      data_mask_high <= break_d_pkg::RESET_HALF; // R8
      data_mask_low  <= break_d_pkg::RESET_HALF; // R8
    end else begin
      if (wr_addr_high)  addr_cmp_high  <= reg_wdata_in;
      if (wr_addr_low)   addr_cmp_low   <= reg_wdata_in;
      if (wr_amask_high) addr_mask_high <= reg_wdata_in;
      if (wr_amask_low)  addr_mask_low  <= reg_wdata_in;
      if (wr_data_high)  data_cmp_high  <= reg_wdata_in; // R5
      if (wr_data_low)   data_cmp_low   <= reg_wdata_in; // R5
      if (wr_dmask_high) data_mask_high <= reg_wdata_in; // R5
      if (wr_dmask_low)  data_mask_low  <= reg_wdata_in; // R5
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xy_bus_enable  <= 1'b0;
      xy_lane_select <= 1'b0;
      irq_mask       <= break_d_pkg::RESET_EVENTS;
    end else begin
      if (wr_bus_ctrl) begin
        xy_bus_enable  <= reg_wdata_in[break_d_pkg::BIT_XY_ENABLE]; // R9
        xy_lane_select <= reg_wdata_in[break_d_pkg::BIT_XY_SELECT]; // R10
      end
      if (wr_irq_mask) irq_mask <= reg_wdata_in[1:0];
    end
  end

  // Matches are sampled on qualifying cycles only; status is sticky, set wins.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_match_out <= 1'b0;
      data_match_out <= 1'b0;
      irq_status     <= break_d_pkg::RESET_EVENTS;
    end else if (manual_reset) begin
      addr_match_out <= 1'b0;
      data_match_out <= 1'b0;
      irq_status     <= break_d_pkg::RESET_EVENTS;
    end else begin
      addr_match_out <= qualifying && addr_hit; // R1
      data_match_out <= qualifying && data_hit; // R12
      irq_status     <= (irq_status & ~({2{wr_irq_status}} & reg_wdata_in[1:0])) | events;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= break_d_pkg::HALF_ZERO;
      first_cycle   <= 1'b1;
    end else begin
      reg_rdata_out <= reg_rd_in ? read_mux : break_d_pkg::HALF_ZERO;
      first_cycle   <= 1'b0;
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_addr_all_masked;
    cyc_valid_in && !xy_bus_enable && !manual_reset
      && {addr_mask_high, addr_mask_low} == 32'hFFFF_FFFF |=> addr_match_out;
  endproperty
  a_addr_all_masked: assert property (p_addr_all_masked) // R1
    else $error("Fully masked address did not match.");

  property p_x_addr_upper;
    xy_bus_enable && !xy_lane_select && x_valid_in && !manual_reset
      && addr_mask_high == break_d_pkg::HALF_ONES |=> addr_match_out;
  endproperty
  a_x_addr_upper: assert property (p_x_addr_upper) // R2
    else $error("X lane address mask upper half not applied.");

  property p_int_data;
    cyc_valid_in && !xy_bus_enable && !manual_reset
      && cyc_data_in == {data_cmp_high, data_cmp_low} |=> data_match_out;
  endproperty
  a_int_data: assert property (p_int_data) // R3
    else $error("Internal bus data equal to compare did not match.");

  property p_y_data;
    xy_bus_enable && xy_lane_select && y_valid_in && !manual_reset
      && y_data_lines_in == data_cmp_low |=> data_match_out;
  endproperty
  a_y_data: assert property (p_y_data) // R4
    else $error("Y lane data equal to low compare did not match.");

  property p_mask_readback;
    reg_wr_in && reg_addr_in == break_d_pkg::OFF_DMASK_LOW ##1
      reg_rd_in && reg_addr_in == break_d_pkg::OFF_DMASK_LOW
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_mask_readback: assert property (p_mask_readback) // R5
    else $error("Data mask low half did not read back.");

  property p_x_data_mask;
    xy_bus_enable && !xy_lane_select && x_valid_in && !manual_reset
      && data_mask_high == break_d_pkg::HALF_ONES |=> data_match_out;
  endproperty
  a_x_data_mask: assert property (p_x_data_mask) // R6 R7 R11
    else $error("Fully masked X lane data did not match.");

  property p_power_on_clear;
    first_cycle |-> data_mask_high == break_d_pkg::RESET_HALF
      && data_mask_low == break_d_pkg::RESET_HALF;
  endproperty
  a_power_on_clear: assert property (p_power_on_clear) // R8
    else $error("Data mask not clear after power-on reset.");

  property p_bus_enable;
    !xy_bus_enable && !cyc_valid_in |=> !addr_match_out && !data_match_out;
  endproperty
  a_bus_enable: assert property (p_bus_enable) // R9
    else $error("Match without an internal bus cycle.");

  property p_lane_select;
    xy_bus_enable && xy_lane_select && !y_valid_in |=> !data_match_out ##1 1'b1;
  endproperty
  a_lane_select: assert property (p_lane_select) // R10
    else $error("Y lane selected but match without Y cycle.");

  property p_qualify;
    !qualifying |=> !data_match_out;
  endproperty
  a_qualify: assert property (p_qualify) // R12
    else $error("Data match outside a qualifying cycle.");

  c_int_match: cover property (cyc_valid_in && !xy_bus_enable ##1 data_match_out);
  c_x_match: cover property (xy_bus_enable && !xy_lane_select ##1 data_match_out);
  c_y_match: cover property (xy_bus_enable && xy_lane_select ##1 addr_match_out);
  c_irq: cover property (irq_out);

endmodule

// File: break_d_pkg.sv
// Constants for the channel D address and data match block.
// Assumes a 16-bit register port with a 4-bit word address.
package break_d_pkg;

  localparam int REG_DATA_W = 16;
  localparam int REG_ADDR_W = 4;
  localparam int BUS_W      = 32;
  localparam int HALF_W     = 16;

  localparam logic [3:0] OFF_ADDR_HIGH  = 4'h0;
  localparam logic [3:0] OFF_ADDR_LOW   = 4'h1;
  localparam logic [3:0] OFF_AMASK_HIGH = 4'h2;
  localparam logic [3:0] OFF_AMASK_LOW  = 4'h3;
  localparam logic [3:0] OFF_DATA_HIGH  = 4'h4;
  localparam logic [3:0] OFF_DATA_LOW   = 4'h5;
  localparam logic [3:0] OFF_DMASK_HIGH = 4'h6;
  localparam logic [3:0] OFF_DMASK_LOW  = 4'h7;
  localparam logic [3:0] OFF_BUS_CTRL   = 4'h8;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h9;
  localparam logic [3:0] OFF_IRQ_MASK   = 4'hA;
  localparam logic [3:0] OFF_MATCH_STATE = 4'hB;

  localparam int BIT_XY_ENABLE = 9;
  localparam int BIT_XY_SELECT = 8;
  localparam int BIT_EV_ADDR   = 0;
  localparam int BIT_EV_DATA   = 1;
  localparam int BIT_ST_ENABLE = 2;
  localparam int BIT_ST_SELECT = 3;

  localparam logic [15:0] RESET_HALF   = 16'h0000;
  localparam logic [1:0]  RESET_EVENTS = 2'h0;
  localparam logic [15:0] HALF_ONES    = 16'hFFFF;
  localparam logic [15:0] HALF_ZERO    = 16'h0000;
  localparam logic [15:0] WORD_BIT0    = 16'h0001;

endpackage

// File: masked_compare.sv
// Masked equality compare of a bus value against a compare value.
// Assumes the mask has a one in every bit that takes no part.
`timescale 1ns/1ps
module masked_compare #(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] value_in,
  input  wire logic [WIDTH-1:0] compare_in,
  input  wire logic [WIDTH-1:0] mask_in,
  output logic                  hit_out
);

  wire logic [WIDTH-1:0] diff_bits;

  // A set mask bit hides a mismatch in that position.
  assign diff_bits = (value_in ^ compare_in) & ~mask_in;
  assign hit_out   = (diff_bits == '0);

endmodule

// File: break_d_bus_model.sv
// Model of the processor side: internal, X and Y memory bus cycles.
// Assumes one cycle per call; idle lines then carry the inverse of their last value.
`timescale 1ns/1ps
module break_d_bus_model (
  input  wire logic        mclk_in,
  output logic             cyc_valid_out,
  output logic [31:0]      cyc_addr_out,
  output logic [31:0]      cyc_data_out,
  output logic             x_valid_out,
  output logic [15:0]      x_addr_out,
  output logic [15:0]      x_data_out,
  output logic             y_valid_out,
  output logic [15:0]      y_addr_out,
  output logic [15:0]      y_data_out
);
  initial begin
    cyc_valid_out = 1'b0;
    x_valid_out   = 1'b0;
    y_valid_out   = 1'b0;
    cyc_addr_out  = 32'h00000000;
    cyc_data_out  = 32'h00000000;
    x_addr_out    = 16'h0000;
    x_data_out    = 16'h0000;
    y_addr_out    = 16'h0000;
    y_data_out    = 16'h0000;
  end

  // Drives one cycle on the bus picked by kind: 0 internal, 1 X, 2 Y.
  task automatic issue(input logic [1:0] kind, input logic valid, input logic [31:0] addr,
                       input logic [31:0] data);
    @(posedge mclk_in);
    if (kind == 2'h0) begin
      cyc_valid_out <= valid;
      cyc_addr_out  <= addr;
      cyc_data_out  <= data;
    end else if (kind == 2'h1) begin
      x_valid_out <= valid;
      x_addr_out  <= addr[15:0];
      x_data_out  <= data[15:0];
    end else begin
      y_valid_out <= valid;
      y_addr_out  <= addr[15:0];
      y_data_out  <= data[15:0];
    end
    @(posedge mclk_in);
    cyc_valid_out <= 1'b0;
    x_valid_out   <= 1'b0;
    y_valid_out   <= 1'b0;
    cyc_addr_out  <= ~cyc_addr_out;
    cyc_data_out  <= ~cyc_data_out;
    x_addr_out    <= ~x_addr_out;
    x_data_out    <= ~x_data_out;
    y_addr_out    <= ~y_addr_out;
    y_data_out    <= ~y_data_out;
  endtask
endmodule

// File: break_d_match_tb_top.sv
// Testbench for the channel D match block: registers, bus matching, interrupt.
// Assumes one 125 MHz clock and the bus model on all bus cycle inputs.
`timescale 1ns/1ps
module break_d_match_tb_top;
  logic        mclk_in;
  logic        reset_n_in;
  logic        manual_reset_n;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        cyc_valid;
  logic [31:0] cyc_addr;
  logic [31:0] cyc_data;
  logic        x_valid;
  logic [15:0] x_addr;
  logic [15:0] x_data;
  logic        y_valid;
  logic [15:0] y_addr;
  logic [15:0] y_data;
  logic        addr_match;
  logic        data_match;
  logic        irq;
  int          mismatches;
  int          samples_checked;

  break_d_bus_model break_d_bus_model_i (
    .mclk_in(mclk_in), .cyc_valid_out(cyc_valid), .cyc_addr_out(cyc_addr),
    .cyc_data_out(cyc_data), .x_valid_out(x_valid), .x_addr_out(x_addr),
    .x_data_out(x_data), .y_valid_out(y_valid), .y_addr_out(y_addr), .y_data_out(y_data)
  );

  break_d_match break_d_match_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .manual_reset_n_in(manual_reset_n),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .cyc_valid_in(cyc_valid),
    .cyc_addr_in(cyc_addr), .cyc_data_in(cyc_data), .x_valid_in(x_valid),
    .x_addr_in(x_addr), .x_data_lines_in(x_data), .y_valid_in(y_valid),
    .y_addr_in(y_addr), .y_data_lines_in(y_data), .addr_match_out(addr_match),
    .data_match_out(data_match), .irq_out(irq)
  );

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask

  // Writes a register and reads it back in the very next cycle.
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata_out", {16'h0000, reg_rdata}, {16'h0000, d});
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata_out", {16'h0000, reg_rdata}, {16'h0000, exp});
  endtask

  task automatic bus(input logic [1:0] kind, input logic valid, input logic [31:0] addr,
                     input logic [31:0] data, input logic exp_a, input logic exp_d);
    break_d_bus_model_i.issue(kind, valid, addr, data);
    #1;
    check("addr_match_out", {31'h00000000, addr_match}, {31'h00000000, exp_a});
    check("data_match_out", {31'h00000000, data_match}, {31'h00000000, exp_d});
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge mclk_in);
    #1;
    check("irq_out", {31'h00000000, irq}, {31'h00000000, exp});
  endtask

  initial begin
    repeat (5000) @(posedge mclk_in);
    mismatches++;
    wrap_up();
  end

  initial begin
    reset_n_in      = 1'b0;
    manual_reset_n  = 1'b1;
    reg_addr        = 4'h0;
    reg_wdata       = 16'h0000;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    mismatches      = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (int a = 4; a <= 8; a++) begin
      rd(a[3:0], 16'h0000);
    end
    wr(4'h4, 16'h1234);
    wr(4'h5, 16'h5678);
    wr(4'h6, 16'h00F0);
    wr(4'h7, 16'h0F00);
    rd(4'h4, 16'h1234);
    rd(4'h5, 16'h5678);
    rd(4'h6, 16'h00F0);
    rd(4'h7, 16'h0F00);
    wr(4'hC, 16'hFFFF);
    rd(4'hC, 16'h0000);
    wr(4'h6, 16'h0000);
    wr_rd(4'h7, 16'h0001);
    wr(4'h0, 16'hA5A5);
    wr(4'h1, 16'h5A5A);
    bus(2'h0, 1'b1, 32'hA5A55A5A, 32'h12345678, 1'b1, 1'b1);
    bus(2'h0, 1'b1, 32'hA5B55A5A, 32'h56781234, 1'b0, 1'b0);
    bus(2'h0, 1'b0, 32'hA5A55A5A, 32'h12345678, 1'b0, 1'b0);
    wr(4'h2, 16'h0010);
    bus(2'h0, 1'b1, 32'hA5B55A5A, 32'h12345679, 1'b1, 1'b1);
    bus(2'h0, 1'b1, 32'hA5A55A5A, 32'h12355678, 1'b1, 1'b0);
    wr(4'h8, 16'h0200);
    rd(4'h8, 16'h0200);
    bus(2'h1, 1'b1, 32'h0000A5A4, 32'h00001234, 1'b1, 1'b1);
    bus(2'h1, 1'b1, 32'h0000A5B5, 32'h00001235, 1'b1, 1'b0);
    bus(2'h1, 1'b1, 32'h00000000, 32'h00005678, 1'b0, 1'b0);
    bus(2'h0, 1'b1, 32'hA5A55A5A, 32'h12345678, 1'b0, 1'b0);
    wr(4'h8, 16'h0300);
    bus(2'h2, 1'b1, 32'h00005A5A, 32'h00005679, 1'b1, 1'b1);
    bus(2'h2, 1'b1, 32'h00005A4A, 32'h00005778, 1'b0, 1'b0);
    bus(2'h1, 1'b1, 32'h0000A5A5, 32'h00001234, 1'b0, 1'b0);
    wr(4'h9, 16'h0003);
    irq_chk(1'b0);
    wr(4'hA, 16'h0002);
    bus(2'h2, 1'b1, 32'h00005A5A, 32'h00000000, 1'b1, 1'b0);
    irq_chk(1'b0);
    rd(4'h9, 16'h0001);
    bus(2'h2, 1'b1, 32'h00000000, 32'h00005678, 1'b0, 1'b1);
    irq_chk(1'b1);
    wr(4'h9, 16'h0003);
    #1;
    check("irq_out", {31'h00000000, irq}, 32'h00000000);
    wr(4'h2, 16'hFFFF);
    wr(4'h3, 16'hFFFF);
    wr(4'h6, 16'hFFFF);
    wr(4'h8, 16'h0000);
    bus(2'h0, 1'b1, 32'h00000000, 32'h12345678, 1'b1, 1'b1);
    wr(4'h8, 16'h0200);
    bus(2'h1, 1'b1, 32'h00000000, 32'h0000FFFF, 1'b1, 1'b1);
    rd(4'h9, 16'h0003);
    @(posedge mclk_in);
    manual_reset_n <= 1'b0;
    repeat (4) @(posedge mclk_in);
    manual_reset_n <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(4'h9, 16'h0000);
    irq_chk(1'b0);
    wrap_up();
  end
endmodule
